// *** rtl/dct_pkg.sv ***
package dct_pkg;

    // Register addresses on the special function register port.
    localparam logic [7:0] ADDR_CTRL  = 8'h88;
    localparam logic [7:0] ADDR_MODE  = 8'h89;
    localparam logic [7:0] ADDR_T0LO  = 8'h8A;
    localparam logic [7:0] ADDR_T1LO  = 8'h8B;
    localparam logic [7:0] ADDR_T0HI  = 8'h8C;
    localparam logic [7:0] ADDR_T1HI  = 8'h8D;
    localparam logic [7:0] ADDR_CLK   = 8'h8E;

    // All registers reset to zero; an unmapped read answers this value.
    localparam logic [7:0] REG_RST    = 8'h00;

    // Bit positions in timer_control_status.
    localparam int TF1 = 7;
    localparam int TR1 = 6;
    localparam int TF0 = 5;
    localparam int TR0 = 4;
    localparam int IE1 = 3;
    localparam int IT1 = 2;
    localparam int IE0 = 1;
    localparam int IT0 = 0;

    // Bit positions in timer_mode_config.
    localparam int TIMER1_PIN_GATING_B = 7;
    localparam int CSEL1_B = 6;
    localparam int MODE1_H = 5;
    localparam int MODE1_L = 4;
    localparam int TIMER0_PIN_GATING_B = 3;
    localparam int CSEL0_B = 2;
    localparam int MODE0_H = 1;
    localparam int MODE0_L = 0;

    // Bit positions and write mask of timer_clock_config.
    localparam int          CKS1_B     = 4;
    localparam int          CKS0_B     = 3;
    localparam int          SCA_H      = 1;
    localparam int          SCA_L      = 0;
    localparam logic [7:0]  CLK_WMASK  = 8'h1B;

    // Mode field codes.
    localparam logic [1:0] MODE_13     = 2'h0;
    localparam logic [1:0] MODE_16     = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT  = 2'h3;

    // Prescale field codes and divider terminal counts.
    localparam logic [1:0] SCA_DIV12   = 2'h0;
    localparam logic [1:0] SCA_DIV4    = 2'h1;
    localparam logic [1:0] SCA_DIV48   = 2'h2;
    localparam logic [1:0] SCA_EXT8    = 2'h3;
    localparam logic [5:0] LAST_DIV12  = 6'h0B;
    localparam logic [5:0] LAST_DIV4   = 6'h03;
    localparam logic [5:0] LAST_DIV48  = 6'h2F;
    localparam logic [2:0] LAST_EXT8   = 3'h7;

    // Counter terminal values.
    localparam logic [12:0] CNT13_MAX  = 13'h1FFF;
    localparam logic [15:0] CNT16_MAX  = 16'hFFFF;
    localparam logic [7:0]  CNT8_MAX   = 8'hFF;

    // Pin synchroniser lanes and their reset level; only the interrupt lanes reset high.
    localparam int         PIN_EV0     = 0;
    localparam int         PIN_EV1     = 1;
    localparam int         PIN_IRQ0    = 2;
    localparam int         PIN_IRQ1    = 3;
    localparam int         PIN_XOSC    = 4;
    localparam logic [4:0] SYNC_RST    = 5'h0C;

    // One access on the register port.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dct_sfr_req_t;

endpackage

// *** rtl/dct_timer01.sv ***
`timescale 1ns/100ps
// Summary of operation
// [RL1] Mode code 3 on timer 0 splits its count bytes into two 8-bit counters.
// [RL2] Split low byte uses timer 0 run, select, gate, flag; event or clock source.
// [RL3] Split high byte is a timer only, clocked by system or prescaled clock.
// [RL4] Split high byte runs on timer 1 run bit and sets timer 1 flag.
// [RL5] Timer 1 with timer 0 split ignores run bit, events, flag; overflow still exported.
// [RL6] Mode code 3 on timer 1 stops it; the only stop while timer 0 splits.
// [RL7] Overflow flags set by hardware, cleared by software or interrupt vectoring.
// [RL8] Run bits at 6 and 4 enable their timer when one.
// [RL9] External flags follow chosen edge or level, read inverse pin, edge clears on vector.
// [RL10] Type bit zero means low level, one means falling edge.
// [RL11] Gate bit one makes the timer also need its interrupt pin high.
// [RL12] Counter select one counts falling edges of the timer event pin.
// [RL13] Mode field: 13-bit, 16-bit, 8-bit reload, split or inactive.
// [RL14] Clock select zero picks prescaled clock, one system clock; ignored counting events.
// [RL15] Prescale field gives divide by 12, 4, 48, or external clock by 8.
// [RL16] Divided external clock is synchronised; outside keeps it at or below system clock.
// [RL17] Clock register bits 7-5 and 2 read zero and ignore writes.
// [RL18] Counts are readable, writable byte pairs; every register resets to zero.
// [RL19] In 13-bit mode wrapping from all ones sets the overflow flag.
// [RL20] Reload mode low-byte overflow sets flag and reloads from unchanged high byte.
// [RL21] Event and gate pins hold each level at least two system clocks.
// [RL22] Setting a run bit keeps the count; counting resumes from the loaded value.
// [RL23] In 16-bit mode wrap to zero and flag set happen in one cycle.
// [RL24] A clearing write meeting a new overflow leaves the flag set.
module dct_timer01 (
    input  wire logic                  clk,             // System clock.
    input  wire logic                  sys_rst,         // Synchronous reset, active high.
    input  wire dct_pkg::dct_sfr_req_t sfr_req,         // Register port access.
    output logic [7:0]                 sfr_rdata,       // Read data, valid the cycle after rd.
    input  wire logic                  ack_timer0,      // Processor vectors to timer 0 handler.
    input  wire logic                  ack_timer1,      // Processor vectors to timer 1 handler.
    input  wire logic                  ack_ext_irq0,    // Processor vectors to external 0 handler.
    input  wire logic                  ack_ext_irq1,    // Processor vectors to external 1 handler.
    input  wire logic                  timer0_event_pin,// Timer 0 event pin.
    input  wire logic                  timer1_event_pin,// Timer 1 event pin.
    input  wire logic                  irq_pin_zero_n,  // Interrupt 0 pin, active low.
    input  wire logic                  irq_pin_one_n,   // Interrupt 1 pin, active low.
    input  wire logic                  ext_osc_clk,     // External oscillator, sampled.
    output logic                       timer0_irq,      // Timer 0 overflow flag.
    output logic                       timer1_irq,      // Timer 1 overflow flag.
    output logic                       ext_irq0,        // External interrupt 0 flag.
    output logic                       ext_irq1,        // External interrupt 1 flag.
    output logic                       timer1_overflow  // One-cycle timer 1 overflow pulse.
);

    logic [7:0]  ctrl;
    logic [7:0]  tmode;
    logic [7:0]  ckcfg;
    logic [7:0]  t0lo;
    logic [7:0]  t0hi;
    logic [7:0]  t1lo;
    logic [7:0]  t1hi;
    logic [4:0]  pin_meta;
    logic [4:0]  pin_sync;
    logic [4:0]  pin_prev;
    logic [4:0]  pin_fall;
    logic        xosc_rise;
    logic [5:0]  pre_cnt;
    logic [5:0]  pre_last;
    logic [2:0]  ext_cnt;
    logic        pre_tick;
    logic        wr_ctrl;
    logic        wr_t0;
    logic        wr_t1;
    logic        split;
    logic        t0_run;
    logic        t0_inc;
    logic        t0hi_inc;
    logic        t1_run;
    logic        t1_inc;
    logic [16:0] step0;
    logic [16:0] step1;
    logic        t0_ovf;
    logic        t0hi_ovf;
    logic        t1_ovf;
    logic        next_tf0;
    logic        next_tf1;

    // Counts one tick in the given mode; the top bit flags the overflow.
    function automatic logic [16:0] dct_step(input logic [1:0] mode, input logic [7:0] hi,
                                             input logic [7:0] lo);
        logic [12:0] c13;
        logic [15:0] c16;
        logic [16:0] res;
        c13 = {hi, lo[4:0]} + 13'h0001;
        c16 = {hi, lo} + 16'h0001;
        case (mode)
            dct_pkg::MODE_13: begin
                res = {({hi, lo[4:0]} == dct_pkg::CNT13_MAX), c13[12:5], lo[7:5], c13[4:0]}; // RL19
            end
            dct_pkg::MODE_16: begin
                res = {({hi, lo} == dct_pkg::CNT16_MAX), c16}; // RL23
            end
            dct_pkg::MODE_RELOAD: begin
                res = {(lo == dct_pkg::CNT8_MAX), hi, (lo == dct_pkg::CNT8_MAX) ? hi : c16[7:0]}; // RL20
            end
            default: begin
                res = {(lo == dct_pkg::CNT8_MAX), hi, c16[7:0]}; // RL1
            end
        endcase
        return res;
    endfunction

    // Two-stage synchronisers for every pin; the third stage keeps the last level for edges.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_meta <= dct_pkg::SYNC_RST;
            pin_sync <= dct_pkg::SYNC_RST;
            pin_prev <= dct_pkg::SYNC_RST;
        end else begin
            pin_meta <= {ext_osc_clk, irq_pin_one_n, irq_pin_zero_n, timer1_event_pin, timer0_event_pin};
            pin_sync <= pin_meta; // RL21
            pin_prev <= pin_sync;
        end
    end

    // Edge detection on synchronised levels only.
    assign pin_fall  = pin_prev & ~pin_sync;
    assign xosc_rise = pin_sync[dct_pkg::PIN_XOSC] & ~pin_prev[dct_pkg::PIN_XOSC]; // RL16

    // Terminal count of the system clock divider for the chosen prescale.
    always_comb begin
        case (ckcfg[dct_pkg::SCA_H:dct_pkg::SCA_L])
            dct_pkg::SCA_DIV4:  pre_last = dct_pkg::LAST_DIV4;
            dct_pkg::SCA_DIV48: pre_last = dct_pkg::LAST_DIV48;
            default:            pre_last = dct_pkg::LAST_DIV12;
        endcase
    end

    // Shared prescaler: a one-cycle tick per divided period, or per eight rising oscillator edges.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pre_cnt  <= '0;
            ext_cnt  <= '0;
            pre_tick <= 1'b0;
        end else if (ckcfg[dct_pkg::SCA_H:dct_pkg::SCA_L] == dct_pkg::SCA_EXT8) begin
            pre_cnt  <= '0;
            ext_cnt  <= xosc_rise ? ext_cnt + 3'h1 : ext_cnt;
            pre_tick <= xosc_rise && (ext_cnt == dct_pkg::LAST_EXT8); // RL15 RL16
        end else begin
            ext_cnt  <= '0;
            pre_cnt  <= (pre_cnt >= pre_last) ? 6'h00 : pre_cnt + 6'h01;
            pre_tick <= (pre_cnt >= pre_last); // RL15
        end
    end

    // Write strobes; a count write that hits either byte holds that timer for the cycle.
    assign wr_ctrl = sfr_req.wr && (sfr_req.addr == dct_pkg::ADDR_CTRL);
    assign wr_t0   = sfr_req.wr && (sfr_req.addr == dct_pkg::ADDR_T0LO || sfr_req.addr == dct_pkg::ADDR_T0HI);
    assign wr_t1   = sfr_req.wr && (sfr_req.addr == dct_pkg::ADDR_T1LO || sfr_req.addr == dct_pkg::ADDR_T1HI);

    // Run and tick decisions for the three counters.
    assign split  = (tmode[dct_pkg::MODE0_H:dct_pkg::MODE0_L] == dct_pkg::MODE_SPLIT); // RL1
    assign t0_run = ctrl[dct_pkg::TR0] && (!tmode[dct_pkg::TIMER0_PIN_GATING_B] || pin_sync[dct_pkg::PIN_IRQ0]); // RL8 RL11 RL2
    assign t0_inc = t0_run && (tmode[dct_pkg::CSEL0_B] ? pin_fall[dct_pkg::PIN_EV0] // RL12
                                : (ckcfg[dct_pkg::CKS0_B] || pre_tick)); // RL14
    assign t0hi_inc = split && ctrl[dct_pkg::TR1] && (ckcfg[dct_pkg::CKS0_B] || pre_tick); // RL3 RL4
    assign t1_run = split || (ctrl[dct_pkg::TR1] && (!tmode[dct_pkg::TIMER1_PIN_GATING_B] || pin_sync[dct_pkg::PIN_IRQ1])); // RL5
    assign t1_inc = (tmode[dct_pkg::MODE1_H:dct_pkg::MODE1_L] != dct_pkg::MODE_SPLIT) && t1_run // RL6
                    && ((tmode[dct_pkg::CSEL1_B] && !split) ? pin_fall[dct_pkg::PIN_EV1]
                        : (ckcfg[dct_pkg::CKS1_B] || pre_tick)); // RL5 RL12 RL14

    // Next count values and overflow events.
    assign step0    = dct_step(tmode[dct_pkg::MODE0_H:dct_pkg::MODE0_L], t0hi, t0lo); // RL13
    assign step1    = dct_step(tmode[dct_pkg::MODE1_H:dct_pkg::MODE1_L], t1hi, t1lo); // RL13
    assign t0_ovf   = t0_inc && step0[16] && !wr_t0;
    assign t0hi_ovf = t0hi_inc && (t0hi == dct_pkg::CNT8_MAX) && !wr_t0;
    assign t1_ovf   = t1_inc && step1[16] && !wr_t1;

    // Overflow flags: hardware set beats any clear in the same cycle.
    assign next_tf0 = t0_ovf || (wr_ctrl ? sfr_req.wdata[dct_pkg::TF0] : (ctrl[dct_pkg::TF0] && !ack_timer0)); // RL24
    assign next_tf1 = t0hi_ovf || (t1_ovf && !split) // RL4 RL5
                      || (wr_ctrl ? sfr_req.wdata[dct_pkg::TF1] : (ctrl[dct_pkg::TF1] && !ack_timer1)); // RL24

    // Control and status register, flags included.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl <= dct_pkg::REG_RST; // RL18
        end else begin
            ctrl[dct_pkg::TF0] <= next_tf0; // RL7
            ctrl[dct_pkg::TF1] <= next_tf1; // RL7
            if (wr_ctrl) begin
                ctrl[dct_pkg::TR1] <= sfr_req.wdata[dct_pkg::TR1];
                ctrl[dct_pkg::TR0] <= sfr_req.wdata[dct_pkg::TR0];
                ctrl[dct_pkg::IT1] <= sfr_req.wdata[dct_pkg::IT1];
                ctrl[dct_pkg::IT0] <= sfr_req.wdata[dct_pkg::IT0];
            end
            // Level type copies the inverted pin; edge type latches a fall until cleared.
            if (!ctrl[dct_pkg::IT0]) begin
                ctrl[dct_pkg::IE0] <= !pin_sync[dct_pkg::PIN_IRQ0]; // RL9 RL10
            end else begin
                ctrl[dct_pkg::IE0] <= pin_fall[dct_pkg::PIN_IRQ0] // RL9 RL10
                    || (wr_ctrl ? sfr_req.wdata[dct_pkg::IE0] : (ctrl[dct_pkg::IE0] && !ack_ext_irq0));
            end
            if (!ctrl[dct_pkg::IT1]) begin
                ctrl[dct_pkg::IE1] <= !pin_sync[dct_pkg::PIN_IRQ1]; // RL9 RL10
            end else begin
                ctrl[dct_pkg::IE1] <= pin_fall[dct_pkg::PIN_IRQ1] // RL9 RL10
                    || (wr_ctrl ? sfr_req.wdata[dct_pkg::IE1] : (ctrl[dct_pkg::IE1] && !ack_ext_irq1));
            end
        end
    end

    // Mode and clock configuration; reserved clock bits never store.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tmode <= dct_pkg::REG_RST;
            ckcfg <= dct_pkg::REG_RST;
        end else if (sfr_req.wr) begin
            if (sfr_req.addr == dct_pkg::ADDR_MODE) begin
                tmode <= sfr_req.wdata;
            end
            if (sfr_req.addr == dct_pkg::ADDR_CLK) begin
                ckcfg <= sfr_req.wdata & dct_pkg::CLK_WMASK; // RL17
            end
        end
    end

    // Timer 0 count bytes; a write wins, otherwise the count advances from its held value.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            t0lo <= dct_pkg::REG_RST;
            t0hi <= dct_pkg::REG_RST;
        end else if (wr_t0) begin
            if (sfr_req.addr == dct_pkg::ADDR_T0LO) begin
                t0lo <= sfr_req.wdata; // RL18
            end else begin
                t0hi <= sfr_req.wdata; // RL18
            end
        end else begin
            if (t0_inc) begin
                t0lo <= step0[7:0]; // RL22
                if (!split) begin
                    t0hi <= step0[15:8];
                end
            end
            if (t0hi_inc) begin
                t0hi <= t0hi + 8'h01; // RL3
            end
        end
    end

    // Timer 1 count bytes.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            t1lo <= dct_pkg::REG_RST;
            t1hi <= dct_pkg::REG_RST;
        end else if (wr_t1) begin
            if (sfr_req.addr == dct_pkg::ADDR_T1LO) begin
                t1lo <= sfr_req.wdata; // RL18
            end else begin
                t1hi <= sfr_req.wdata; // RL18
            end
        end else if (t1_inc) begin
            t1lo <= step1[7:0]; // RL22
            t1hi <= step1[15:8];
        end
    end

    // Overflow pulse for baud-rate and conversion-trigger users.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timer1_overflow <= 1'b0;
        end else begin
            timer1_overflow <= t1_ovf; // RL5
        end
    end

    // Registered read port; unmapped addresses answer zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sfr_rdata <= dct_pkg::REG_RST;
        end else if (sfr_req.rd) begin
            case (sfr_req.addr)
                dct_pkg::ADDR_CTRL: sfr_rdata <= ctrl;
                dct_pkg::ADDR_MODE: sfr_rdata <= tmode;
                dct_pkg::ADDR_T0LO: sfr_rdata <= t0lo;
                dct_pkg::ADDR_T1LO: sfr_rdata <= t1lo;
                dct_pkg::ADDR_T0HI: sfr_rdata <= t0hi;
                dct_pkg::ADDR_T1HI: sfr_rdata <= t1hi;
                dct_pkg::ADDR_CLK:  sfr_rdata <= ckcfg; // RL17
                default:            sfr_rdata <= dct_pkg::REG_RST;
            endcase
        end
    end

    // Interrupt request outputs are the flag flip-flops themselves.
    assign timer0_irq = ctrl[dct_pkg::TF0];
    assign timer1_irq = ctrl[dct_pkg::TF1];
    assign ext_irq0   = ctrl[dct_pkg::IE0];
    assign ext_irq1   = ctrl[dct_pkg::IE1];

    // A 16-bit wrap yields zero and a set flag on the next edge.
    wrap_sixteen_a: assert property (@(posedge clk) disable iff (sys_rst) // RL23
        (t0_inc && !wr_t0 && tmode[1:0] == dct_pkg::MODE_16 && {t0hi, t0lo} == dct_pkg::CNT16_MAX)
        |=> ({t0hi, t0lo} == 16'h0000 && timer0_irq))
        else $error("16-bit wrap did not clear count and set flag");

    // A 13-bit wrap clears the used bits and sets the flag.
    wrap_thirteen_a: assert property (@(posedge clk) disable iff (sys_rst) // RL19
        (t1_inc && !wr_t1 && !split && tmode[5:4] == dct_pkg::MODE_13 && {t1hi, t1lo[4:0]} == dct_pkg::CNT13_MAX)
        |=> ({t1hi, t1lo[4:0]} == 13'h0000 && timer1_irq))
        else $error("13-bit wrap misbehaved");

    // Reload mode refills the low byte from an untouched high byte.
    reload_value_a: assert property (@(posedge clk) disable iff (sys_rst) // RL20
        (t0_inc && !wr_t0 && tmode[1:0] == dct_pkg::MODE_RELOAD && t0lo == dct_pkg::CNT8_MAX)
        |=> (t0lo == $past(t0hi) && $stable(t0hi) && timer0_irq))
        else $error("reload did not copy high byte");

    // The split high byte overflow lands in the timer 1 flag.
    split_high_a: assert property (@(posedge clk) disable iff (sys_rst) // RL4
        (split && ctrl[dct_pkg::TR1] && ckcfg[dct_pkg::CKS0_B] && !wr_t0 && t0hi == dct_pkg::CNT8_MAX)
        |=> (t0hi == 8'h00 && timer1_irq))
        else $error("split high byte overflow lost");

    // Timer 1 in code 3 never moves by itself.
    t1_inactive_a: assert property (@(posedge clk) disable iff (sys_rst) // RL6
        (tmode[5:4] == dct_pkg::MODE_SPLIT && !wr_t1) |=> ($stable(t1lo) && $stable(t1hi) && !timer1_overflow))
        else $error("inactive timer 1 counted");

    // Timer 0 with run bit low holds its low byte.
    run_off_a: assert property (@(posedge clk) disable iff (sys_rst) // RL8
        (!ctrl[dct_pkg::TR0] && !wr_t0) |=> $stable(t0lo))
        else $error("timer 0 counted while disabled");

    // A clearing write in an overflow cycle keeps the flag.
    set_wins_a: assert property (@(posedge clk) disable iff (sys_rst) // RL24
        (t0_ovf && wr_ctrl && !sfr_req.wdata[dct_pkg::TF0]) |=> timer0_irq)
        else $error("overflow lost to clearing write");

    // Reserved clock bits always read back as zero.
    clk_reserved_a: assert property (@(posedge clk) disable iff (sys_rst) // RL17
        (sfr_req.rd && sfr_req.addr == dct_pkg::ADDR_CLK) |=> (sfr_rdata[7:5] == 3'h0 && !sfr_rdata[2]))
        else $error("reserved clock bits not zero");

    // Level type flag mirrors the inverted synchronised pin.
    level_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // RL9
        (!ctrl[dct_pkg::IT0] && !$past(ctrl[dct_pkg::IT0]) && !$past(sys_rst))
        |-> (ext_irq0 == !$past(pin_sync[dct_pkg::PIN_IRQ0])))
        else $error("level flag not inverse of pin");

endmodule

// *** test/dct_pin_model.sv ***
`timescale 1ns/100ps
// Far-side pins: timer event pins, interrupt pins and a free-running external oscillator.
module dct_pin_model (
    input  wire logic clk,    // System clock that paces every event and interrupt pin change.
    output logic      ev0,    // Timer 0 event pin, idle high.
    output logic      ev1,    // Timer 1 event pin, idle high.
    output logic      irq0_n, // Interrupt 0 pin, idle high.
    output logic      irq1_n, // Interrupt 1 pin, idle high.
    output logic      osc     // External oscillator at half the system rate.
);
    // Pins start idle; the oscillator is offset so its edges never meet the clock edge.
    initial begin
        ev0 = 1'b1;
        ev1 = 1'b1;
        irq0_n = 1'b1;
        irq1_n = 1'b1;
        osc = 1'b0;
        #1;
        forever #4 osc = ~osc;
    end

    // One falling event; each level is held three clocks so the sampler cannot miss it.
    task automatic ev_fall(input int i);
        if (i == 0) ev0 = 1'b0; else ev1 = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        if (i == 0) ev0 = 1'b1; else ev1 = 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // Moves one interrupt pin and holds the new level three clocks.
    task automatic set_irq(input int i, input logic v);
        if (i == 0) irq0_n = v; else irq1_n = v;
        repeat (3) @(posedge clk);
        #1;
    endtask
endmodule

// *** test/tb_dct_timer01.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_dct_timer01;
    logic                  clk;
    logic                  sys_rst;
    dct_pkg::dct_sfr_req_t req;
    logic [7:0]            rdata;
    logic [3:0]            acks;
    logic                  ev0, ev1, irq0_n, irq1_n, osc;
    logic                  t0_irq, t1_irq, x0_irq, x1_irq, t1_ovf;
    logic                  saw_ovf, saw_irq;
    int                    errors, compares, n;
    int                    div_exp [4] = '{12, 4, 48, 16};

    dct_timer01 dct_timer01_inst (.clk(clk), .sys_rst(sys_rst), .sfr_req(req), .sfr_rdata(rdata),
        .ack_timer0(acks[0]), .ack_timer1(acks[1]), .ack_ext_irq0(acks[2]), .ack_ext_irq1(acks[3]),
        .timer0_event_pin(ev0), .timer1_event_pin(ev1), .irq_pin_zero_n(irq0_n),
        .irq_pin_one_n(irq1_n), .ext_osc_clk(osc), .timer0_irq(t0_irq), .timer1_irq(t1_irq),
        .ext_irq0(x0_irq), .ext_irq1(x1_irq), .timer1_overflow(t1_ovf));
    dct_pin_model dct_pin_model_inst (.clk(clk), .ev0(ev0), .ev1(ev1), .irq0_n(irq0_n),
        .irq1_n(irq1_n), .osc(osc));

    // The clock toggles every half period of 2 ns.
    always #2 clk = ~clk;

    // Register write, one strobe cycle.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        #1 req.wr = 1'b0;
    endtask

    // Register read, compared one cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        #1 req.rd = 1'b0;
        `CHK(rdata, e)
    endtask

    // One-cycle vectoring acknowledge.
    task automatic ack(input int i);
        @(posedge clk);
        #1 acks = 4'h1 << i;
        @(posedge clk);
        #1 acks = 4'h0;
    endtask

    // Counts clocks until the timer 0 flag is seen, bounded.
    task automatic wait_t0();
        while (t0_irq !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        `CHK(t0_irq, 1'b1)
    endtask

    task automatic final_report();
        if (errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Watchdog cuts a hang well beyond the expected run length.
    initial begin
        #200000;
        errors++;
        final_report();
    end

    // Main sequence.
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        req = '0;
        acks = 4'h0;
        errors = 0;
        compares = 0;
        repeat (5) @(posedge clk);
        #1 sys_rst = 1'b0;
        for (int a = 8'h88; a <= 8'h8F; a++) rd(a[7:0], 8'h00);
        wr(dct_pkg::ADDR_CLK, 8'hFF);
        rd(dct_pkg::ADDR_CLK, 8'h1B);
        // 16-bit wrap counted from event pin falls.
        wr(dct_pkg::ADDR_CLK, 8'h00);
        wr(dct_pkg::ADDR_MODE, 8'h05);
        wr(dct_pkg::ADDR_T0LO, 8'hFE);
        wr(dct_pkg::ADDR_T0HI, 8'hFF);
        wr(dct_pkg::ADDR_CTRL, 8'h10);
        repeat (2) dct_pin_model_inst.ev_fall(0);
        rd(dct_pkg::ADDR_T0LO, 8'h00);
        rd(dct_pkg::ADDR_T0HI, 8'h00);
        rd(dct_pkg::ADDR_CTRL, 8'h30);
        ack(0);
        `CHK(t0_irq, 1'b0)
        // Gated counting follows the interrupt 0 pin.
        wr(dct_pkg::ADDR_MODE, 8'h0D);
        dct_pin_model_inst.set_irq(0, 1'b0);
        `CHK(x0_irq, 1'b1)
        dct_pin_model_inst.ev_fall(0);
        rd(dct_pkg::ADDR_T0LO, 8'h00);
        dct_pin_model_inst.set_irq(0, 1'b1);
        dct_pin_model_inst.ev_fall(0);
        rd(dct_pkg::ADDR_T0LO, 8'h01);
        // Timer 1 in 13-bit mode wraps from all ones.
        wr(dct_pkg::ADDR_MODE, 8'h40);
        wr(dct_pkg::ADDR_T1LO, 8'h1F);
        wr(dct_pkg::ADDR_T1HI, 8'hFF);
        wr(dct_pkg::ADDR_CTRL, 8'h40);
        dct_pin_model_inst.ev_fall(1);
        rd(dct_pkg::ADDR_T1LO, 8'h00);
        rd(dct_pkg::ADDR_T1HI, 8'h00);
        `CHK(t1_irq, 1'b1)
        ack(1);
        `CHK(t1_irq, 1'b0)
        // Auto-reload keeps the high byte.
        wr(dct_pkg::ADDR_MODE, 8'h06);
        wr(dct_pkg::ADDR_T0HI, 8'hA5);
        wr(dct_pkg::ADDR_T0LO, 8'hFF);
        wr(dct_pkg::ADDR_CTRL, 8'h10);
        `CHK(t1_irq, 1'b0)
        dct_pin_model_inst.ev_fall(0);
        rd(dct_pkg::ADDR_T0LO, 8'hA5);
        rd(dct_pkg::ADDR_T0HI, 8'hA5);
        `CHK(t0_irq, 1'b1)
        // Edge and level detection of the external interrupts.
        wr(dct_pkg::ADDR_CTRL, 8'h01);
        dct_pin_model_inst.set_irq(0, 1'b0);
        `CHK(x0_irq, 1'b1)
        dct_pin_model_inst.set_irq(0, 1'b1);
        `CHK(x0_irq, 1'b1)
        ack(2);
        `CHK(x0_irq, 1'b0)
        dct_pin_model_inst.set_irq(1, 1'b0);
        `CHK(x1_irq, 1'b1)
        dct_pin_model_inst.set_irq(1, 1'b1);
        `CHK(x1_irq, 1'b0)
        // Edge type on interrupt 1 latches the fall until vectoring.
        wr(dct_pkg::ADDR_CTRL, 8'h04);
        dct_pin_model_inst.set_irq(1, 1'b0);
        `CHK(x1_irq, 1'b1)
        dct_pin_model_inst.set_irq(1, 1'b1);
        `CHK(x1_irq, 1'b1)
        ack(3);
        `CHK(x1_irq, 1'b0)
        // Prescaler period measured between reload overflows, one per tick.
        wr(dct_pkg::ADDR_CTRL, 8'h00);
        wr(dct_pkg::ADDR_MODE, 8'h02);
        wr(dct_pkg::ADDR_T0HI, 8'hFF);
        wr(dct_pkg::ADDR_T0LO, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            wr(dct_pkg::ADDR_CLK, i[7:0]);
            wr(dct_pkg::ADDR_CTRL, 8'h10);
            n = 0;
            wait_t0();
            ack(0);
            n = 2;
            wait_t0();
            `CHK(n, div_exp[i])
            wr(dct_pkg::ADDR_CTRL, 8'h00);
        end
        // Overflow every clock; a clearing write in an overflow cycle keeps the flag.
        wr(dct_pkg::ADDR_CLK, 8'h08);
        wr(dct_pkg::ADDR_CTRL, 8'h10);
        wr(dct_pkg::ADDR_CTRL, 8'h10);
        `CHK(t0_irq, 1'b1)
        wr(dct_pkg::ADDR_CTRL, 8'h00);
        // Split mode: timer 1 runs without its flag, high byte drives it instead.
        wr(dct_pkg::ADDR_CLK, 8'h18);
        wr(dct_pkg::ADDR_T1LO, 8'hF0);
        wr(dct_pkg::ADDR_T1HI, 8'hFF);
        wr(dct_pkg::ADDR_T0LO, 8'hFF);
        wr(dct_pkg::ADDR_T0HI, 8'h10);
        wr(dct_pkg::ADDR_MODE, 8'h17);
        wr(dct_pkg::ADDR_CTRL, 8'h10);
        saw_ovf = 1'b0;
        saw_irq = 1'b0;
        fork
            dct_pin_model_inst.ev_fall(0);
            repeat (40) begin
                @(posedge clk);
                #1 saw_ovf |= t1_ovf;
                saw_irq |= t1_irq;
            end
        join
        `CHK(saw_ovf, 1'b1)
        `CHK(saw_irq, 1'b0)
        rd(dct_pkg::ADDR_T0LO, 8'h00);
        rd(dct_pkg::ADDR_T0HI, 8'h10);
        `CHK(t0_irq, 1'b1)
        wr(dct_pkg::ADDR_T0HI, 8'hFF);
        wr(dct_pkg::ADDR_CTRL, 8'h50);
        repeat (4) @(posedge clk);
        #1 `CHK(t1_irq, 1'b1)
        wr(dct_pkg::ADDR_MODE, 8'h37);
        saw_ovf = 1'b0;
        repeat (300) begin
            @(posedge clk);
            #1 saw_ovf |= t1_ovf;
        end
        `CHK(saw_ovf, 1'b0)
        final_report();
    end
endmodule
